//--- core/evt_ctl_regs.sv
/*
 * page select, event summary, revision and event count / record masks, with the
 * per-port event counters and flag latches they steer, behind an apb slave.
 * assumes per-port event pulses arrive one cycle wide from logic on pclk.
 */
`timescale 1ns/1ps
module evt_ctl_regs
    import evt_ctl_pkg::*;
#(
    parameter int NUM_PORTS = 13,
    parameter logic [7:0] DEV_REV_ID = 8'h5a // arbitrary value
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire port_evt_s evt [NUM_PORTS],
    input wire logic flags_clr,
    input wire logic [3:0] irq_cfg_n,
    output logic [3:0] page_sel,
    output summary_s summary,
    output logic event_log_irq
);

    // ==========================================================
    // state
    logic [3:0] page_q;
    logic [7:0] lower_en_q;
    logic [7:0] upper_opt_q;
    logic [7:0] record_en_q;
    logic [15:0] cnt_q [NUM_PORTS];
    logic [7:0] flag_q [NUM_PORTS];
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    summary_s summary_q;
    logic irq_q;

    // ==========================================================
    // apb decode
    wire logic [5:0] idx = paddr[7:2];
    wire logic acc = ce & psel & penable & ~pready_q;
    wire logic done = ce & psel & penable & pready_q;
    wire logic hit_page = (idx == IDX_PAGE);
    wire logic on_ctrl = (page_q == PAGE_CTRL);
    wire logic hit_id = on_ctrl & (idx == IDX_DEV_ID);
    wire logic hit_lower = on_ctrl & (idx == IDX_LOWER_EN);
    wire logic hit_upper = on_ctrl & (idx == IDX_UPPER_OPT);
    wire logic hit_record = on_ctrl & (idx == IDX_RECORD_EN);
    wire logic in_cnt_a = (page_q == PAGE_CNT_A) & (idx >= IDX_CNT_FIRST) & (idx <= IDX_CNT_LAST_P3);
    wire logic in_cnt_b = (page_q == PAGE_CNT_B) & (idx >= IDX_CNT_FIRST) & (idx <= IDX_CNT_LAST_P4);
    wire logic [4:0] cnt_off = 5'(idx - IDX_CNT_FIRST);
    wire logic [4:0] cnt_lin = in_cnt_b ? 5'(cnt_off + CNT_P4_BASE) : cnt_off;
    wire logic [3:0] cnt_port = cnt_lin[4:1];
    wire logic cnt_hi = cnt_lin[0];
    wire logic hit_cnt = (in_cnt_a | in_cnt_b) & (32'(cnt_port) < NUM_PORTS);
    wire logic [15:0] cnt_sel = hit_cnt ? cnt_q[cnt_port] : 16'h0000;
    wire logic [7:0] cnt_byte = cnt_hi ? cnt_sel[15:8] : cnt_sel[7:0];
    wire logic mapped = hit_page | hit_id | hit_lower | hit_upper | hit_record | hit_cnt;
    wire logic wr_done = done & pwrite;
    wire logic rd_done = done & ~pwrite;
    wire logic [7:0] wbyte = pwdata[7:0];

    // ==========================================================
    // read mux
    wire logic [7:0] rd_byte =
        hit_page ? {summary_q, page_q} :
        hit_id ? DEV_REV_ID :
        hit_lower ? lower_en_q :
        hit_upper ? (upper_opt_q & UPPER_OPT_WMASK) :
        hit_record ? record_en_q :
        hit_cnt ? cnt_byte : 8'h00;

    // ==========================================================
    // apb answer: one wait cycle, then pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else if (ce) begin
            pready_q <= acc;
            if (acc) begin
                pslverr_q <= ~mapped;
                prdata_q <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            end
        end
    end

    // ==========================================================
    // control registers, committed at the completing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_q <= PAGE_RST;
            lower_en_q <= LOWER_EN_RST;
            upper_opt_q <= UPPER_OPT_RST;
            record_en_q <= RECORD_EN_RST;
        end else if (ce && wr_done) begin
            if (hit_page)
                page_q <= wbyte[3:0];
            if (hit_lower)
                lower_en_q <= wbyte;
            if (hit_upper)
                upper_opt_q <= wbyte & UPPER_OPT_WMASK;
            if (hit_record)
                record_en_q <= wbyte;
        end
    end

    // ==========================================================
    // per-port counters and flag latches
    logic [NUM_PORTS-1:0] below_v;
    logic [NUM_PORTS-1:0] above_v;
    logic [NUM_PORTS-1:0] full_v;
    logic [NUM_PORTS-1:0] flag_v;
    wire logic opt_clr = upper_opt_q[POS_CLEAR_ON_READ];
    wire logic opt_frz = upper_opt_q[POS_FREEZE_AT_FULL];

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        wire logic any_col = evt[p].tx_col | evt[p].rx_col | evt[p].late_col;
        wire logic [7:0] cls_hit = evt[p].cls & lower_en_q;
        wire logic rx_ok = cls_hit[POS_RECEIVE] & ~any_col;
        wire logic [3:0] inc_cls = 4'(cls_hit[0]) + 4'(cls_hit[1]) + 4'(cls_hit[2]) + 4'(cls_hit[3])
            + 4'(cls_hit[4]) + 4'(rx_ok) + 4'(cls_hit[6]) + 4'(cls_hit[7]);
        wire logic [3:0] inc_col = 4'(evt[p].tx_col & upper_opt_q[POS_TX_COL])
            + 4'(evt[p].rx_col & upper_opt_q[POS_RX_COL])
            + 4'(evt[p].late_col & upper_opt_q[POS_LATE_COL]);
        wire logic [3:0] inc = 4'(inc_cls + inc_col);
        wire logic rd_clr = rd_done & opt_clr & hit_cnt & cnt_hi & (cnt_port == 4'(p));
        wire logic [15:0] base = rd_clr ? 16'h0000 : cnt_q[p];
        wire logic [16:0] sum = {1'b0, base} + {13'h0000, inc};
        wire logic [15:0] cnt_d =
            (opt_frz && base == CNT_FULL) ? CNT_FULL :
            (opt_frz && sum[16]) ? CNT_FULL :
            sum[15:0];
        wire logic [7:0] rec_hit = {evt[p].cls.bad_link, evt[p].cls.partition, evt[p].late_col,
            evt[p].cls[4:0]} & record_en_q;

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cnt_q[p] <= 16'h0000;
                flag_q[p] <= 8'h00;
            end else if (ce) begin
                cnt_q[p] <= cnt_d;
                flag_q[p] <= (flags_clr ? 8'h00 : flag_q[p]) | rec_hit; // set wins over clear
            end
        end

        assign below_v[p] = cnt_q[p] < CNT_LOW_LIMIT;
        assign above_v[p] = cnt_q[p] > CNT_HIGH_LIMIT;
        assign full_v[p] = cnt_q[p] == CNT_FULL;
        assign flag_v[p] = |(flag_q[p] & record_en_q);
    end

    // ==========================================================
    // summary status and event log interrupt
    summary_s summary_d;
    assign summary_d = '{full_counter_status: |full_v, high_count_status: |above_v,
                         low_count_status: |below_v, flag_found_status: |flag_v};
    wire logic irq_d = (summary_d.flag_found_status & ~irq_cfg_n[0])
        | (summary_d.low_count_status & ~irq_cfg_n[1])
        | (summary_d.high_count_status & ~irq_cfg_n[2])
        | (summary_d.full_counter_status & ~irq_cfg_n[3]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            summary_q <= '0;
            irq_q <= 1'b0;
        end else if (ce) begin
            summary_q <= summary_d;
            irq_q <= irq_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign page_sel = page_q;
    assign summary = summary_q;
    assign event_log_irq = irq_q;

    // ==========================================================
    // assertions
    wire port_evt_s e0 = evt[0];
    wire logic quiet0 = ~flags_clr & ~(rd_done & hit_cnt);

    sequence s_page_write;
        ce && wr_done && hit_page;
    endsequence

    property p_page_write;
        @(posedge pclk) disable iff (!presetn)
        s_page_write |=> (page_q == $past(pwdata[3:0]));
    endproperty
    a_page_write: assert property (p_page_write) else $error("page write not applied");

    property p_page_hold;
        @(posedge pclk) disable iff (!presetn)
        !(ce && wr_done && hit_page) |=> $stable(page_q);
    endproperty
    a_page_hold: assert property (p_page_hold) else $error("page changed without write");

    sequence s_read_req(logic [5:0] i);
        ce && acc && !pwrite && idx == i;
    endsequence

    property p_page_read;
        @(posedge pclk) disable iff (!presetn)
        s_read_req(IDX_PAGE) |=> pready_q && prdata_q[3:0] == page_q && !pslverr_q;
    endproperty
    a_page_read: assert property (p_page_read) else $error("page readback wrong");

    property p_dev_id;
        @(posedge pclk) disable iff (!presetn)
        s_read_req(IDX_DEV_ID) ##0 on_ctrl |=> prdata_q[7:0] == DEV_REV_ID;
    endproperty
    a_dev_id: assert property (p_dev_id) else $error("revision code wrong");

    property p_full;
        @(posedge pclk) disable iff (!presetn)
        ce && cnt_q[0] == CNT_FULL |=> summary_q.full_counter_status;
    endproperty
    a_full: assert property (p_full) else $error("full status missing");

    property p_low_high;
        @(posedge pclk) disable iff (!presetn)
        ce |=> summary_q.low_count_status == $past(|below_v) && summary_q.high_count_status == $past(|above_v);
    endproperty
    a_low_high: assert property (p_low_high) else $error("count status wrong");

    property p_freeze;
        @(posedge pclk) disable iff (!presetn)
        ce && opt_frz && cnt_q[0] == CNT_FULL && quiet0 |=> cnt_q[0] == CNT_FULL;
    endproperty
    a_freeze: assert property (p_freeze) else $error("frozen counter moved");

    property p_rx_col;
        @(posedge pclk) disable iff (!presetn)
        ce && quiet0 && upper_opt_q[5:3] == 3'b000 && lower_en_q == 8'h20 && e0.cls.receive && e0.tx_col
            |=> $stable(cnt_q[0]);
    endproperty
    a_rx_col: assert property (p_rx_col) else $error("collided receive counted");

    property p_late_twice;
        @(posedge pclk) disable iff (!presetn)
        ce && quiet0 && lower_en_q == 8'h00 && upper_opt_q[5:3] == 3'b101 && e0.tx_col && e0.late_col
            && !e0.rx_col && cnt_q[0] < CNT_HIGH_LIMIT |=> cnt_q[0] == 16'($past(cnt_q[0]) + 16'h0002);
    endproperty
    a_late_twice: assert property (p_late_twice) else $error("late collision not doubled");

    property p_irq;
        @(posedge pclk) disable iff (!presetn)
        ce && !irq_cfg_n[3] && summary_d.full_counter_status |=> event_log_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("event log interrupt missing");

    property p_irq_off;
        @(posedge pclk) disable iff (!presetn)
        ce && irq_cfg_n == 4'hf |=> !event_log_irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("event log interrupt without enable");

    property p_ce_freeze;
        @(posedge pclk) disable iff (!presetn)
        !ce |=> $stable(page_q) && $stable(cnt_q[0]) && $stable(flag_q[0])
            && $stable(summary_q) && $stable(pready_q) && $stable(irq_q);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while enable low");

    sequence s_access;
        ce && acc;
    endsequence

    sequence s_answer;
        pready_q && prdata_q[31:8] == 24'h00_0000;
    endsequence

    property p_answer;
        @(posedge pclk) disable iff (!presetn)
        s_access |=> s_answer;
    endproperty
    a_answer: assert property (p_answer) else $error("bus answer missing");

    property p_ready_pulse;
        @(posedge pclk) disable iff (!presetn)
        ce && pready_q |=> !pready_q;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

    property p_unmapped;
        @(posedge pclk) disable iff (!presetn)
        s_access ##0 !mapped |=> pslverr_q && prdata_q == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

    property p_clear_read;
        @(posedge pclk) disable iff (!presetn)
        rd_done && opt_clr && hit_cnt && cnt_hi && cnt_port == 4'h0 && e0 == '0 |=> cnt_q[0] == 16'h0000;
    endproperty
    a_clear_read: assert property (p_clear_read) else $error("counter not cleared by read");

    property p_keep_read;
        @(posedge pclk) disable iff (!presetn)
        rd_done && !opt_clr && e0 == '0 |=> $stable(cnt_q[0]);
    endproperty
    a_keep_read: assert property (p_keep_read) else $error("counter changed by read");

    property p_jabber_count;
        @(posedge pclk) disable iff (!presetn)
        ce && quiet0 && !opt_frz && lower_en_q[0] && e0 == port_evt_s'(11'h001)
            |=> cnt_q[0] == 16'($past(cnt_q[0]) + 16'h0001);
    endproperty
    a_jabber_count: assert property (p_jabber_count) else $error("enabled event not counted");

    property p_wrap;
        @(posedge pclk) disable iff (!presetn)
        ce && quiet0 && !opt_frz && cnt_q[0] == CNT_FULL && g_port[0].inc == 4'h1 |=> cnt_q[0] == 16'h0000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("full counter did not wrap");

    property p_flag_found;
        @(posedge pclk) disable iff (!presetn)
        ce && |(flag_q[0] & record_en_q) |=> summary_q.flag_found_status;
    endproperty
    a_flag_found: assert property (p_flag_found) else $error("flag found status missing");

    property p_flag_set;
        @(posedge pclk) disable iff (!presetn)
        ce && e0.cls.jabber && record_en_q[0] |=> flag_q[0][0];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("enabled event not latched");

    property p_late_only;
        @(posedge pclk) disable iff (!presetn)
        ce && !e0.late_col |=> flag_q[0][5] == ($past(flag_q[0][5]) && !$past(flags_clr));
    endproperty
    a_late_only: assert property (p_late_only) else $error("late collision flag set by other event");

    property p_high_level;
        @(posedge pclk) disable iff (!presetn)
        ce && cnt_q[0] > CNT_HIGH_LIMIT |=> summary_q.high_count_status;
    endproperty
    a_high_level: assert property (p_high_level) else $error("high count status missing");

    property p_low_level;
        @(posedge pclk) disable iff (!presetn)
        ce && cnt_q[0] < CNT_LOW_LIMIT |=> summary_q.low_count_status;
    endproperty
    a_low_level: assert property (p_low_level) else $error("low count status missing");

endmodule : evt_ctl_regs

//--- core/evt_ctl_pkg.sv
/*
 * shared constants and carriers for the event count and page control register bank.
 * assumes an apb master with 32-bit data; registers hold 8 bits in the low byte lane.
 */
package evt_ctl_pkg;

    // ==========================================================
    // register indices (byte address = 4 * index)
    localparam logic [5:0] IDX_PAGE = 6'h10;
    localparam logic [5:0] IDX_DEV_ID = 6'h11;
    localparam logic [5:0] IDX_LOWER_EN = 6'h12;
    localparam logic [5:0] IDX_UPPER_OPT = 6'h13;
    localparam logic [5:0] IDX_RECORD_EN = 6'h14;
    localparam logic [5:0] IDX_CNT_FIRST = 6'h12;
    localparam logic [5:0] IDX_CNT_LAST_P3 = 6'h1f;
    localparam logic [5:0] IDX_CNT_LAST_P4 = 6'h1d;
    localparam logic [4:0] CNT_P4_BASE = 5'h0e;

    // ==========================================================
    // pages
    localparam logic [3:0] PAGE_CTRL = 4'h0;
    localparam logic [3:0] PAGE_CNT_A = 4'h3;
    localparam logic [3:0] PAGE_CNT_B = 4'h4;

    // ==========================================================
    // field positions
    localparam int POS_FLAG_FOUND = 4;
    localparam int POS_LOW_COUNT = 5;
    localparam int POS_HIGH_COUNT = 6;
    localparam int POS_FULL_COUNT = 7;
    localparam int POS_RECEIVE = 5;
    localparam int POS_CLEAR_ON_READ = 0;
    localparam int POS_FREEZE_AT_FULL = 1;
    localparam int POS_TX_COL = 3;
    localparam int POS_RX_COL = 4;
    localparam int POS_LATE_COL = 5;
    localparam logic [7:0] UPPER_OPT_WMASK = 8'h3b;

    // ==========================================================
    // reset values and counter thresholds
    localparam logic [3:0] PAGE_RST = 4'h0;
    localparam logic [7:0] LOWER_EN_RST = 8'h00;
    localparam logic [7:0] UPPER_OPT_RST = 8'h00;
    localparam logic [7:0] RECORD_EN_RST = 8'h00;
    localparam logic [15:0] CNT_LOW_LIMIT = 16'h00ff;
    localparam logic [15:0] CNT_HIGH_LIMIT = 16'hc000;
    localparam logic [15:0] CNT_FULL = 16'hffff;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic bad_link;
        logic partition;
        logic receive;
        logic short_ev;
        logic no_sfd;
        logic carrier_err;
        logic elastic_buf_err;
        logic jabber;
    } class_evt_s;

    typedef struct packed {
        logic late_col;
        logic rx_col;
        logic tx_col;
        class_evt_s cls;
    } port_evt_s;

    typedef struct packed {
        logic full_counter_status;
        logic high_count_status;
        logic low_count_status;
        logic flag_found_status;
    } summary_s;

endpackage : evt_ctl_pkg

//--- testbench/tb.sv
/*
 * self-checking bench for the event count and page control register bank.
 * assumes evt_ctl_pkg and evt_ctl_regs are compiled first; only port 0 sees events.
 */
`timescale 1ns/1ps
module tb;
    import evt_ctl_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, flags_clr, event_log_irq;
    logic ce;
    logic [7:0] paddr, r, lfsr, lo, up;
    logic [31:0] pwdata, prdata;
    logic [3:0] irq_cfg_n, page_sel;
    logic [15:0] cnt_exp;
    summary_s summary;
    port_evt_s evt [13];
    port_evt_s ev;
    int failures, n_checks;

    evt_ctl_regs DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .evt(evt), .flags_clr(flags_clr), .irq_cfg_n(irq_cfg_n),
        .page_sel(page_sel), .summary(summary), .event_log_irq(event_log_irq));

    // ==========================================================
    // expectation functions
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next

    function automatic int incr(input port_evt_s e);
        int n;
        logic col;
        col = e.tx_col | e.rx_col | e.late_col;
        n = $countones(e.cls & lo & 8'hdf) + int'(e.cls.receive & lo[5] & !col);
        return n + int'(e.tx_col & up[3]) + int'(e.rx_col & up[4]) + int'(e.late_col & up[5]);
    endfunction : incr

    function automatic logic [15:0] nxt(input logic [15:0] c, input int n);
        if (up[1] && (int'(c) + n > 65535))
            return 16'hffff;
        return c + 16'(n);
    endfunction : nxt

    // ==========================================================
    // bus and compare tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd, output logic [7:0] q,
                       output logic e);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        q = prdata[7:0];
        e = pslverr;
        chk({31'h0, prdata[31:8] != 24'h0}, 32'h0);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic e;
        apb(1'b1, a, d, r, e);
        chk(e, 0);
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input logic experr);
        logic e;
        apb(1'b0, a, 8'h00, r, e);
        chk({e, r}, {experr, exp});
    endtask : rchk

    task automatic pulse(input port_evt_s e, input int n);
        repeat (n) begin
            evt[0] <= e;
            cnt_exp = nxt(cnt_exp, incr(e));
            @(posedge pclk);
        end
        evt[0] <= '0;
        repeat (3) @(posedge pclk);
    endtask : pulse

    task automatic cnt_chk();
        rchk(8'h48, cnt_exp[7:0], 1'b0);
        rchk(8'h4c, cnt_exp[15:8], 1'b0);
    endtask : cnt_chk

    task automatic conclude();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    // ==========================================================
    // clock, watchdog, main sequence
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    initial begin
        #100us;
        failures++;
        conclude();
    end

    initial begin
        {presetn, psel, penable, pwrite, flags_clr, paddr, pwdata} = '0;
        irq_cfg_n = 4'hf;
        ce = 1'b1;
        for (int i = 0; i < 13; i++)
            evt[i] = '0;
        lfsr = 8'd70;
        cnt_exp = 16'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(8'h40, 8'h20, 1'b0);
        rchk(8'h44, 8'h5a, 1'b0);
        for (int i = 0; i < 3; i++)
            rchk(8'h48 + 8'(4 * i), 8'h00, 1'b0);
        rchk(8'h54, 8'h00, 1'b1);
        wr(8'h44, 8'hff);
        rchk(8'h44, 8'h5a, 1'b0);
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            wr(8'h48, lfsr);
            rchk(8'h48, lfsr, 1'b0);
            wr(8'h50, ~lfsr);
            rchk(8'h50, ~lfsr, 1'b0);
            wr(8'h4c, lfsr & UPPER_OPT_WMASK);
            rchk(8'h4c, lfsr & UPPER_OPT_WMASK, 1'b0);
            wr(8'h40, {lfsr[7:4], 4'h0});
            rchk(8'h40, 8'h20, 1'b0);
        end
        irq_cfg_n <= 4'b1101;
        repeat (3) @(posedge pclk);
        chk(event_log_irq, 1);
        irq_cfg_n <= 4'hf;
        repeat (3) @(posedge pclk);
        chk(event_log_irq, 0);
        wr(8'h50, 8'h00);
        lo = lfsr | 8'h21;
        up = 8'h38;
        wr(8'h48, lo);
        wr(8'h4c, up);
        wr(8'h40, 8'h03);
        rchk(8'h40, 8'h23, 1'b0);
        chk({summary, page_sel}, 8'h23);
        for (int i = 0; i < 12; i++) begin
            lfsr = lfsr_next(lfsr);
            ev = (i < 4) ? port_evt_s'(11'h020 | (11'h100 << i)) : port_evt_s'({lfsr[2:0], lfsr});
            pulse(ev, 1 + i % 3);
            cnt_chk();
        end
        wr(8'h40, 8'h00);
        up = 8'h39;
        wr(8'h4c, up);
        wr(8'h40, 8'h03);
        cnt_chk();
        cnt_exp = 16'h0;
        cnt_chk();
        wr(8'h40, 8'h00);
        lo = 8'h20;
        up = 8'h00;
        wr(8'h48, lo);
        wr(8'h4c, up);
        wr(8'h40, 8'h03);
        ce <= 1'b0;
        evt[0] <= port_evt_s'(11'h020);
        repeat (2) @(posedge pclk);
        evt[0] <= '0;
        ce <= 1'b1;
        @(posedge pclk);
        pulse(port_evt_s'(11'h120), 2);
        cnt_chk();
        wr(8'h40, 8'h00);
        lo = 8'h00;
        up = 8'h29;
        wr(8'h48, lo);
        wr(8'h4c, up);
        wr(8'h40, 8'h03);
        pulse(port_evt_s'(11'h500), 1);
        cnt_chk();
        cnt_exp = 16'h0;
        wr(8'h40, 8'h00);
        lo = 8'hdf;
        up = 8'h38;
        wr(8'h48, lo);
        wr(8'h4c, up);
        wr(8'h40, 8'h04);
        pulse(port_evt_s'(11'h7ff), 6553);
        rchk(8'h40, 8'h64, 1'b0);
        chk({summary, page_sel}, 8'h64);
        rchk(8'h74, 8'h00, 1'b0);
        rchk(8'h78, 8'h00, 1'b1);
        pulse(port_evt_s'(11'h001), 5);
        rchk(8'h40, 8'he4, 1'b0);
        chk({summary, page_sel}, 8'he4);
        irq_cfg_n <= 4'b0111;
        repeat (3) @(posedge pclk);
        chk(event_log_irq, 1);
        irq_cfg_n <= 4'hf;
        repeat (3) @(posedge pclk);
        chk(event_log_irq, 0);
        wr(8'h40, 8'h00);
        up = 8'h3a;
        wr(8'h4c, up);
        wr(8'h40, 8'h03);
        pulse(port_evt_s'(11'h001), 2);
        cnt_chk();
        wr(8'h40, 8'h00);
        up = 8'h38;
        wr(8'h4c, up);
        wr(8'h40, 8'h03);
        pulse(port_evt_s'(11'h001), 1);
        cnt_chk();
        wr(8'h40, 8'h00);
        wr(8'h50, 8'h01);
        pulse(port_evt_s'(11'h001), 1);
        rchk(8'h40, 8'h30, 1'b0);
        chk({summary, page_sel}, 8'h30);
        flags_clr <= 1'b1;
        @(posedge pclk);
        flags_clr <= 1'b0;
        wr(8'h50, 8'h20);
        pulse(port_evt_s'(11'h001), 1);
        rchk(8'h40, 8'h20, 1'b0);
        pulse(port_evt_s'(11'h400), 1);
        rchk(8'h40, 8'h30, 1'b0);
        conclude();
    end
endmodule : tb
